// >>> rtl/dcf_fifo.sv
/*
 * Dual-mode 9-bit FIFO with standard and first-word-fall-through timing,
 * half-full and programmable almost-empty / almost-full flags, APB access
 * to the offsets and status.
 * Assumes writer and reader share the one clock; pins are synchronous.
 */
// Behaviour
// - mode strap sampled at reset: low standard, high fall-through; held by outside.
// - fall-through mode reports via output_ready and input_ready, not empty/full flags.
// - fall-through first word appears after three edges without a request.
// - words are stored each edge while write_enable_n low and not full.
// - standard empty flag rises after first write, falls on last read; reads ignored empty.
// - standard almost-empty low at n words or fewer, high from n+1.
// - standard half-full low from depth/2+1 words, high again below.
// - standard almost-full low from depth minus m words, high again below.
// - standard full flag low at depth, blocks writes; first read releases it.
// - standard empty and full flags pass through two register stages.
// - fall-through output_ready low when word valid, high after last read.
// - fall-through almost-empty high from n+2 words, low at n+1 or fewer.
// - fall-through half-full threshold one above the standard value.
// - fall-through almost-full low from depth+1 minus m words.
// - fall-through input_ready high at depth+1 words, blocking writes.
// - fall-through output_ready has three stages, input_ready two.
// - load_select high at reset gives both offsets 3FF.
// - load_select low at reset gives both offsets 07F.
`timescale 1ns/1ns
module dcf_fifo
	import dcf_pkg::*;
#(
	parameter int DEPTH = DEPTH_DEFAULT,
	parameter int WIDTH = 9
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             write_enable_n,
	input  wire logic [WIDTH-1:0] data_in,
	input  wire logic             read_enable_n,
	output logic      [WIDTH-1:0] output_bus,
	input  wire logic             mode_select_serial_in,
	input  wire logic             load_select,
	output logic                  empty_flag_n,
	output logic                  full_flag_n,
	output logic                  almost_empty_flag_n,
	output logic                  almost_full_flag_n,
	output logic                  half_full_flag_n,
	output logic                  output_ready,
	output logic                  input_ready,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2 + 1);
	// offsets keep the full default width even when a small depth is built
	localparam int OW = (AW > $bits(OFS_SERIAL_DEFAULT)) ? AW : $bits(OFS_SERIAL_DEFAULT);

	// ********************************
	// reset capture
	// ********************************
	logic         capture;
	dcf_mode_type mode;
	logic         serial_load;
	logic         fall_through_mode;
	logic [1:0]   age;

	assign fall_through_mode = (mode == DCF_FALL);

	// straps are caught on the first edge after release, never under rst
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			capture <= 1'b1;
		end else begin
			capture <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode        <= DCF_STANDARD;
			serial_load <= 1'b0;
		end else if (capture) begin
			mode        <= mode_select_serial_in ? DCF_FALL : DCF_STANDARD;
			serial_load <= load_select;
		end
	end

	// only feeds assertions: edges since release, saturating
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_mode_strap: assert property ($fell(capture) |-> fall_through_mode == $past(mode_select_serial_in))
		else $error("mode not taken from strap");

	// ********************************
	// offsets and APB slave
	// ********************************
	logic [OW-1:0] empty_ofs;
	logic [OW-1:0] full_ofs;
	logic          wr_access;
	logic          mapped;

	assign pready    = 1'b1;
	assign wr_access = psel && penable && pwrite;
	assign mapped    = (paddr == ADDR_EMPTY_OFS) || (paddr == ADDR_FULL_OFS) ||
	                   (paddr == ADDR_STATUS) || (paddr == ADDR_COUNT);
	assign pslverr   = psel && penable && !mapped;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			empty_ofs <= '0;
			full_ofs  <= '0;
		end else if (capture) begin
			empty_ofs <= load_select ? OW'(OFS_SERIAL_DEFAULT) : OW'(OFS_PARALLEL_DEFAULT);
			full_ofs  <= load_select ? OW'(OFS_SERIAL_DEFAULT) : OW'(OFS_PARALLEL_DEFAULT);
		end else if (wr_access && paddr == ADDR_EMPTY_OFS) begin
			empty_ofs <= pwdata[OW-1:0];
		end else if (wr_access && paddr == ADDR_FULL_OFS) begin
			full_ofs <= pwdata[OW-1:0];
		end
	end

	a_offset_default: assert property ($fell(capture) |->
		empty_ofs == ($past(load_select) ? OW'(OFS_SERIAL_DEFAULT) : OW'(OFS_PARALLEL_DEFAULT)) &&
		full_ofs == empty_ofs)
		else $error("offset defaults wrong");

	// ********************************
	// storage and pointers
	// ********************************
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    mem_count;
	logic [CW-1:0]    total;
	logic             out_valid;
	logic             nonempty_d1;
	logic             wr;
	logic             rd_std;
	logic             rd_fw;
	logic             load;
	logic             pop;

	// memory full blocks writes; in fall-through the output word is extra
	assign wr     = !write_enable_n && mem_count != DEPTH_C;
	assign rd_std = !fall_through_mode && !read_enable_n && mem_count != '0;
	assign rd_fw  = fall_through_mode && !read_enable_n && out_valid;
	assign load   = fall_through_mode && nonempty_d1 && mem_count != '0 && (!out_valid || rd_fw);
	assign pop    = rd_std || load;
	assign total  = mem_count + CW'(out_valid);

	always_ff @(posedge clock) begin
		if (wr) begin
			mem[wr_ptr] <= data_in;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			mem_count <= '0;
		end else begin
			if (wr) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			mem_count <= mem_count + CW'(wr) - CW'(pop);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			output_bus <= '0;
		end else if (pop) begin
			output_bus <= mem[rd_ptr];
		end
	end

	// count register, nonempty_d1, out_valid: three stages to the ready flag
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			nonempty_d1 <= 1'b0;
			out_valid   <= 1'b0;
		end else begin
			nonempty_d1 <= mem_count != '0;
			if (load) begin
				out_valid <= 1'b1;
			end else if (rd_fw) begin
				out_valid <= 1'b0;
			end
		end
	end

	a_write_stored: assert property (wr |=> wr_ptr == $past(wr_ptr) + AW'(1))
		else $error("write not stored");
	a_read_idle: assert property (read_enable_n && !load |=> $stable(rd_ptr) && $stable(output_bus))
		else $error("read side moved without request");
	a_empty_ignore: assert property (!fall_through_mode && mem_count == '0 |=> $stable(rd_ptr))
		else $error("read taken while empty");
	a_full_block: assert property (mem_count == DEPTH_C |=> $stable(wr_ptr))
		else $error("write taken while full");
	a_std_no_request: assert property (!fall_through_mode && read_enable_n |=>
		$stable(output_bus))
		else $error("word shown without a read request");
	a_count_step: assert property (age != 2'h0 |->
		mem_count == $past(mem_count) + CW'($past(wr)) - CW'($past(pop)))
		else $error("count moved by more than one word");

	sequence s_first_write;
		fall_through_mode && total == '0 && wr;
	endsequence
	sequence s_falls_through;
		output_ready ##1 output_ready ##1 !output_ready;
	endsequence
	a_fall_through: assert property (s_first_write |=> s_falls_through)
		else $error("first word not shown after three edges");

	// ********************************
	// reader-side guards, strap and count checks
	// ********************************
	a_fall_load: assert property (fall_through_mode && load |=>
		!output_ready)
		else $error("loaded word not flagged ready");
	a_ft_empty_ignore: assert property (fall_through_mode && total == '0 |=>
		$stable(rd_ptr) && $stable(output_bus))
		else $error("read taken while fall-through side empty");
	a_output_hold: assert property (fall_through_mode && !output_ready && read_enable_n |=>
		$stable(output_bus) && !output_ready)
		else $error("shown word changed without a read");
	a_load_strap: assert property ($fell(capture) |->
		serial_load == $past(load_select))
		else $error("load strap not kept");
	a_ptr_gap: assert property (
		AW'(mem_count) == wr_ptr - rd_ptr)
		else $error("count and pointers disagree");
	a_count_limit: assert property (
		mem_count <= DEPTH_C)
		else $error("memory count beyond depth");

	// ********************************
	// status flags
	// ********************************
	logic [1:0] empty_s;
	logic [1:0] full_s;
	logic [1:0] ir_s;
	logic          ae_low;
	logic          hf_low;
	logic          af_low;

	// compared as int: an offset may exceed a small built depth
	assign ae_low = int'(total) <= int'(empty_ofs) + int'(fall_through_mode);
	assign hf_low = int'(total) >= DEPTH / 2 + 1 + int'(fall_through_mode);
	assign af_low = int'(total) >= DEPTH - int'(full_ofs) + int'(fall_through_mode);

	// two stages so the flags behave like a synchronised pin on the far side
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			empty_s <= 2'b00;
			full_s  <= 2'b11;
			ir_s    <= 2'b00;
		end else begin
			empty_s <= {empty_s[0], mem_count != '0};
			full_s  <= {full_s[0], mem_count != DEPTH_C};
			ir_s    <= {ir_s[0], total == DEPTH_C + CW'(1)};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			almost_empty_flag_n <= 1'b0;
			half_full_flag_n    <= 1'b1;
			almost_full_flag_n  <= 1'b1;
		end else begin
			almost_empty_flag_n <= !ae_low;
			half_full_flag_n    <= !hf_low;
			almost_full_flag_n  <= !af_low;
		end
	end

	// unused flags of the other mode sit at their inactive level
	assign empty_flag_n = fall_through_mode ? 1'b1 : empty_s[1];
	assign full_flag_n  = fall_through_mode ? 1'b1 : full_s[1];
	assign output_ready = fall_through_mode ? !out_valid : 1'b1;
	assign input_ready  = fall_through_mode ? ir_s[1] : 1'b1;

	a_fall_through_mode_flags_idle: assert property (fall_through_mode |-> empty_flag_n && full_flag_n)
		else $error("empty/full used in fall-through");
	a_std_empty_delay: assert property (age == 2'h3 && !fall_through_mode |->
		empty_flag_n == $past(mem_count != '0, 2))
		else $error("empty flag not two stages");
	a_fall_through_mode_ir_delay: assert property (age == 2'h3 && fall_through_mode |->
		input_ready == $past(total == DEPTH_C + CW'(1), 2))
		else $error("input_ready not two stages");
	a_half_full: assert property (age != 2'h0 |->
		half_full_flag_n == !($past(total) >= HALF_C + CW'($past(fall_through_mode))))
		else $error("half-full threshold wrong");

	a_std_ready_idle: assert property (!fall_through_mode |->
		output_ready && input_ready)
		else $error("ready flags used in standard mode");
	a_std_full_delay: assert property (age == 2'h3 && !fall_through_mode |->
		full_flag_n == $past(mem_count != DEPTH_C, 2))
		else $error("full flag not two stages");
	a_almost_empty: assert property (age != 2'h0 |->
		almost_empty_flag_n == (int'($past(total)) > int'($past(empty_ofs)) + int'($past(fall_through_mode))))
		else $error("almost-empty threshold wrong");
	a_almost_full: assert property (age != 2'h0 |->
		almost_full_flag_n == (int'($past(total)) < DEPTH - int'($past(full_ofs)) + int'($past(fall_through_mode))))
		else $error("almost-full threshold wrong");

	// flag edges as the far side sees them, two edges behind the count
	sequence s_std_fill_empty;
		!fall_through_mode && mem_count == '0 && empty_s == 2'b00 && wr;
	endsequence
	sequence s_empty_rises;
		!empty_flag_n ##1 !empty_flag_n ##1 empty_flag_n;
	endsequence
	sequence s_std_fill_last;
		!fall_through_mode && mem_count == DEPTH_C - CW'(1) && full_s == 2'b11 && wr && !pop;
	endsequence
	sequence s_full_falls;
		full_flag_n ##1 full_flag_n ##1 !full_flag_n;
	endsequence
	a_empty_rises: assert property (s_std_fill_empty |=>
		s_empty_rises)
		else $error("empty flag did not rise two edges after first write");
	a_full_falls: assert property (s_std_fill_last |=>
		s_full_falls)
		else $error("full flag did not fall two edges after last write");
	a_ready_release: assert property (fall_through_mode && total == CW'(1) && rd_fw |=>
		output_ready)
		else $error("output_ready still low after last read");
	a_ir_release: assert property (fall_through_mode && total == DEPTH_C + CW'(1) && rd_fw |=>
		##2 !input_ready)
		else $error("input_ready not released by read from full");
	a_ready_blocks: assert property (fall_through_mode && total == DEPTH_C + CW'(1) |->
		!wr)
		else $error("write taken with memory and output word full");

	// ********************************
	// APB read data
	// ********************************
	// latched in the setup cycle so the zero-wait access phase has it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= 32'h0000_0000;
			unique case (paddr)
				ADDR_EMPTY_OFS: prdata[OW-1:0] <= empty_ofs;
				ADDR_FULL_OFS:  prdata[OW-1:0] <= full_ofs;
				ADDR_STATUS: begin
					prdata[STATUS_FALL_THROUGH_MODE_BIT] <= fall_through_mode;
					prdata[STATUS_LOAD_BIT] <= serial_load;
				end
				ADDR_COUNT:     prdata[CW-1:0] <= total;
				default:        prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : dcf_fifo

// >>> rtl/dcf_pkg.sv
/*
 * Constants shared by the dual-mode flag FIFO: register map, offset
 * defaults, mode encoding.
 * Assumes a single clock domain and an APB master with 32-bit data.
 */
package dcf_pkg;
	// ********************************
	// register map (byte addresses)
	// ********************************
	localparam logic [7:0] ADDR_EMPTY_OFS = 8'h00;
	localparam logic [7:0] ADDR_FULL_OFS  = 8'h04;
	localparam logic [7:0] ADDR_STATUS    = 8'h08;
	localparam logic [7:0] ADDR_COUNT     = 8'h0C;

	// ********************************
	// offset defaults and sizes
	// ********************************
	localparam logic [9:0] OFS_SERIAL_DEFAULT   = 10'h3FF;
	localparam logic [9:0] OFS_PARALLEL_DEFAULT = 10'h07F;
	localparam int         DEPTH_DEFAULT        = 65536;
	localparam int         FALL_THROUGH_EDGES   = 3;

	// status register bit positions
	localparam int STATUS_FALL_THROUGH_MODE_BIT = 0;
	localparam int STATUS_LOAD_BIT = 1;

	typedef enum logic [1:0] {
		DCF_STANDARD = 2'b01,
		DCF_FALL     = 2'b10
	} dcf_mode_type;
endpackage : dcf_pkg

// >>> tb/dcf_partner.sv
/*
 * Writer and reader logic standing in front of the FIFO pins.
 * Assumes the bench raises wr_req or rd_req for one clock per word.
 */
`timescale 1ns/1ns
module dcf_partner (
	input  wire logic       wr_req,
	input  wire logic       rd_req,
	input  wire logic [8:0] wdata,
	output logic            write_enable_n,
	output logic            read_enable_n,
	output logic      [8:0] data_in
);
	assign write_enable_n = !wr_req;
	assign read_enable_n  = !rd_req;
	// idle bus shows the inverse, so a stale word never passes as written
	assign data_in = wr_req ? wdata : ~wdata;
endmodule : dcf_partner

// >>> tb/dual_clock_fifo_flag_modes_tb_top.sv
/*
 * Bench for dcf_fifo: a queue model checked after every operation.
 * Assumes one clock for writer, reader and APB, DEPTH shrunk to 16.
 */
`timescale 1ns/1ns
module dual_clock_fifo_flag_modes_tb_top;
	import dcf_pkg::*;
	localparam int D = 16;
	logic        clock = 1'b0, rst = 1'b1, wr_req = 1'b0, rd_req = 1'b0;
	logic        mode_select_serial_in = 1'b0, load_select = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, ft;
	logic        write_enable_n, read_enable_n, empty_flag_n, full_flag_n, output_ready, input_ready;
	logic        almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
	logic [8:0]  wdata = 9'h000, data_in, output_bus, shown;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h08F8;
	logic [8:0]  q[$];
	int          n_fail = 0, samples_checked = 0, cycles = 0, n, m;

	dcf_partner pm (.wr_req, .rd_req, .wdata, .write_enable_n, .read_enable_n, .data_in);
	dcf_fifo #(.DEPTH(D)) DUT (.clock, .rst, .write_enable_n, .data_in, .read_enable_n, .output_bus,
		.mode_select_serial_in, .load_select, .empty_flag_n, .full_flag_n, .almost_empty_flag_n,
		.almost_full_flag_n, .half_full_flag_n, .output_ready, .input_ready, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);

	initial begin
		forever #5 clock = ~clock;
	end

	// runs take well under 2000 cycles per mode
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// ********************************
	// bus and pin drivers, flag check
	// ********************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk_flags();
		int t;
		t = q.size();
		chk(empty_flag_n, ft | (t != 0));
		chk(full_flag_n, ft | (t != D));
		chk(almost_empty_flag_n, t > n + ft);
		chk(half_full_flag_n, t < D / 2 + 1 + ft);
		chk(almost_full_flag_n, t < D - m + ft);
		chk(output_ready, !ft | (t == 0));
		chk(input_ready, !ft | (t == D + 1));
		if (!ft || t != 0)
			chk(output_bus, ft ? q[0] : shown);
	endtask : chk_flags

	task automatic op(input logic w, input logic r);
		logic [8:0] d;
		logic       e;
		d = 9'(xs());
		e = (q.size() == 0);
		@(posedge clock);
		wr_req <= w;
		rd_req <= r;
		wdata <= d;
		@(posedge clock);
		wr_req <= 1'b0;
		rd_req <= 1'b0;
		if (w && q.size() < D + ft)
			q.push_back(d);
		if (r && q.size() != 0)
			shown = q.pop_front();
		for (int k = 1; k < 4; k++) begin
			@(posedge clock);
			#1;
			if (ft && e && w)
				chk(output_ready, k < 2);
		end
		chk_flags();
	endtask : op

	// straps stay put across the release edge
	task automatic rst_dut(input logic fm, input logic ls);
		@(posedge clock);
		rst <= 1'b1;
		mode_select_serial_in <= fm;
		load_select <= ls;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		ft = fm;
		q.delete();
		shown = 9'h000;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, {30'h0, ls, fm});
		apb(1'b0, ADDR_EMPTY_OFS, 32'h0);
		chk(rd, ls ? 32'h3FF : 32'h7F);
		apb(1'b0, ADDR_FULL_OFS, 32'h0);
		chk(rd, ls ? 32'h3FF : 32'h7F);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, ADDR_EMPTY_OFS, 32'h2);
		apb(1'b1, ADDR_FULL_OFS, 32'h3);
		n = 2;
		m = 3;
		// flags take the new offsets one edge after the write lands
		@(posedge clock);
		#1;
		chk_flags();
	endtask : rst_dut

	initial begin
		for (int p = 0; p < 2; p++) begin
			rst_dut(p[0], !p[0]);
			repeat (D + 2) op(1'b1, 1'b0);
			apb(1'b0, ADDR_COUNT, 32'h0);
			chk(rd, q.size());
			repeat (D + 3) op(1'b0, 1'b1);
			repeat (40) begin
				rd = xs();
				op(rd[0], !rd[0]);
			end
		end
		stop_test();
	end
endmodule : dual_clock_fifo_flag_modes_tb_top
